/* File: shared/adcsc_map.vh */
// constants for the converter serial control block
//
// Contract
// - after chip select falls, leading zeros are skipped; first one is the start bit unless the result fifo is full or under seven result bits are out.
// - with chip select low, one input bit shifts in per serial clock rise.
// - control byte bits 6 to 4 form the three-bit channel select field.
// - control byte bit 3 set means unipolar, clear means bipolar conversion.
// - control byte bit 2 set means single-ended to common, clear means differential.
// - track/hold starts tracking on the fall after the fifth control bit.
// - track/hold goes to hold, conversion begins, on the fall after bit eight.
// - acquisition spans three serial clocks, ending on the fall after the last bit.
// - single-ended routes any input against common; differential uses pairs 0/1..6/7.
// - when conversion finishes the hold capacitor returns to the positive node.
// - external clock mode strobe pulses one serial period before the result msb.
// - strobe and serial output change only on serial clock falling edges, or clear to zero on deselect.
// - with input held high each conversion takes exactly 15 serial clocks.
// - an all-ones byte converts input 7 single-ended unipolar, external clock.
// - link is full duplex; bytes shift in on serial clock rises and out on falls.
// - each result is 12 bits, shifted out most significant bit first.
// - bits 1 and 0 pick power and clock mode; both set is external clock.
// - result is straight binary when unipolar, two's complement when bipolar.
// - single-ended codes 000,100,001,101,010,110,011,111 map to inputs 0 to 7.
// - differential: lower two bits pick the pair, upper bit makes odd positive.
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH

`define ADCSC_START_BIT       7
`define ADCSC_SEL_MSB_BIT     6
`define ADCSC_SEL_MID_BIT     5
`define ADCSC_SEL_LSB_BIT     4
`define ADCSC_POLARITY_BIT    3
`define ADCSC_INPUT_CFG_BIT   2
`define ADCSC_PCM_HI_BIT      1
`define ADCSC_PCM_LO_BIT      0

`define ADCSC_MODE_EXT_CLOCK  2'h3
`define ADCSC_CTRL_BITS       4'h8
`define ADCSC_TRACK_AFTER     4'h5
`define ADCSC_RESULT_BITS     4'hC
`define ADCSC_REARM_BITS      4'h7
`define ADCSC_TRIAL_MSB       12'h0800
`define ADCSC_RX_RESET        8'h00
`define ADCSC_PIN_RESET       4'h4

`endif

/* File: core/adcsc_sync.v */
// two flip-flop synchroniser for pins entering the mclk domain
`timescale 1ns/1ps
module adcsc_sync #(
    parameter WIDTH       = 4,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input  wire             mclk,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] pinIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stage1  <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            stage1  <= pinIn;
            syncOut <= stage1;
        end
    end
endmodule // adcsc_sync

/* File: core/adcsc_fifo.v */
// result fifo with valid and ready on both sides
`timescale 1ns/1ps
module adcsc_fifo #(
    parameter WIDTH = 20,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk,
    input  wire             reset_n,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [WIDTH-1:0] outReg;
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            doWrite;
    wire            doRead;
    wire [AW-1:0]   rdPtrNext;

    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = outReg;
    assign rdPtrNext = !doRead ? rdPtr :
                       (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
    assign doWrite  = inValid & inReady;
    assign doRead   = outValid & outReady;

    always @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
        // read register tracks the head word, bypassing a write into the head slot
        if (doWrite && (wrPtr == rdPtrNext)) begin
            outReg <= inData;
        end else begin
            outReg <= mem[rdPtrNext];
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // adcsc_fifo

/* File: core/adcsc_serial_ctrl.v */
// serial control, track/hold sequencing and sar result shifting
`timescale 1ns/1ps
`include "adcsc_map.vh"
module adcsc_serial_ctrl #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        csN,
    input  wire        sclk,
    input  wire        din,
    input  wire        compHigh,
    output reg         doutOut,
    output wire        doutOe,
    output reg         strobeOut,
    output wire        strobeOe,
    output reg         trackMode,
    output reg         capOnPositive,
    output reg  [11:0] dacCode,
    output reg  [2:0]  muxPos,
    output reg  [2:0]  muxNeg,
    output reg         muxNegIsCom,
    output reg         polarityUnipolar,
    output reg  [1:0]  powerClockMode,
    output reg         convActive,
    output wire        resultValid,
    input  wire        resultReady,
    output wire [19:0] resultData
);
    // positive input index for a channel field (msb, mid, lsb)
    function [2:0] posInput;
        input [2:0] sel;
        begin
            posInput = {sel[1], sel[0], sel[2]};
        end
    endfunction

    // negative input index in differential mode: partner of the pair
    function [2:0] negInput;
        input [2:0] sel;
        begin
            negInput = {sel[1], sel[0], ~sel[2]};
        end
    endfunction

    wire [3:0] pinSync;
    wire       csSyncN;
    wire       sclkSync;
    wire       dinSync;
    wire       compSync;
    reg        sclkPrev;
    wire       sclkRise;
    wire       sclkFall;

    reg  [7:0] rxShift;
    reg  [3:0] rxCount;
    reg  [7:0] ctrlByte;
    reg  [3:0] convStep;
    reg        bipolarFlip;

    wire       fifoInReady;
    reg        fifoPush;
    reg [19:0] fifoData;
    wire       startAllowed;
    wire [11:0] trialMask;
    wire [11:0] decidedCode;
    wire [7:0] heldByte;

    adcsc_sync #(
        .WIDTH       (4),
        .RESET_VALUE (`ADCSC_PIN_RESET)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .pinIn   ({compHigh, csN, sclk, din}),
        .syncOut (pinSync)
    );

    assign dinSync  = pinSync[0];
    assign sclkSync = pinSync[1];
    assign csSyncN  = pinSync[2];
    assign compSync = pinSync[3];

    assign sclkRise = sclkSync & ~sclkPrev;
    assign sclkFall = ~sclkSync & sclkPrev;

    // both outputs float while chip select is high
    assign doutOe   = ~csSyncN;
    assign strobeOe = ~csSyncN;

    // new start only when idle or after seven result bits, and room for the result
    assign startAllowed = (~convActive | (convStep >= `ADCSC_REARM_BITS)) & fifoInReady;

    assign trialMask   = `ADCSC_TRIAL_MSB >> convStep;
    assign decidedCode = (dacCode & ~trialMask) | (compSync ? trialMask : 12'h0000);
    assign heldByte    = rxShift;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclkPrev <= 1'b0;
        end else begin
            sclkPrev <= sclkSync;
        end
    end

    // control byte receiver
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxShift          <= `ADCSC_RX_RESET;
            rxCount          <= 4'h0;
            trackMode        <= 1'b0;
            ctrlByte         <= `ADCSC_RX_RESET;
            muxPos           <= 3'h0;
            muxNeg           <= 3'h0;
            muxNegIsCom      <= 1'b1;
            polarityUnipolar <= 1'b1;
            powerClockMode   <= `ADCSC_MODE_EXT_CLOCK;
        end else if (csSyncN) begin
            rxShift   <= `ADCSC_RX_RESET;
            rxCount   <= 4'h0;
            trackMode <= 1'b0;
        end else if (sclkRise) begin
            if (rxCount == 4'h0) begin
                if (dinSync && startAllowed) begin
                    rxShift <= {7'h00, 1'b1};
                    rxCount <= 4'h1;
                end
            end else if (rxCount < `ADCSC_CTRL_BITS) begin
                rxShift <= {rxShift[6:0], dinSync};
                rxCount <= rxCount + 4'h1;
            end
        end else if (sclkFall) begin
            if (rxCount == `ADCSC_TRACK_AFTER) begin
                trackMode <= 1'b1;
            end else if (rxCount == `ADCSC_CTRL_BITS) begin
                trackMode <= 1'b0;
                rxCount   <= 4'h0;
                ctrlByte  <= heldByte;
                // channel, polarity, input and mode fields
                polarityUnipolar <= heldByte[`ADCSC_POLARITY_BIT];
                powerClockMode   <= heldByte[`ADCSC_PCM_HI_BIT:`ADCSC_PCM_LO_BIT];
                muxPos <= posInput(heldByte[`ADCSC_SEL_MSB_BIT:`ADCSC_SEL_LSB_BIT]);
                if (heldByte[`ADCSC_INPUT_CFG_BIT]) begin
                    muxNegIsCom <= 1'b1;
                    muxNeg      <= 3'h0;
                end else begin
                    muxNegIsCom <= 1'b0;
                    muxNeg <= negInput(heldByte[`ADCSC_SEL_MSB_BIT:`ADCSC_SEL_LSB_BIT]);
                end
            end
        end
    end

    // successive approximation and result shifting, all on falling edges
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            convActive    <= 1'b0;
            convStep      <= 4'h0;
            dacCode       <= 12'h0000;
            capOnPositive <= 1'b1;
            strobeOut     <= 1'b0;
            doutOut       <= 1'b0;
            bipolarFlip   <= 1'b0;
            fifoPush      <= 1'b0;
            fifoData      <= 20'h0_0000;
        end else begin
            fifoPush <= 1'b0;
            if (csSyncN) begin
                convActive    <= 1'b0;
                convStep      <= 4'h0;
                capOnPositive <= 1'b1;
                strobeOut     <= 1'b0;
                doutOut       <= 1'b0;
            end else if (sclkFall) begin
                if (rxCount == `ADCSC_CTRL_BITS) begin
                    // hold: capacitor swings to the negative node, trial starts
                    convActive    <= 1'b1;
                    convStep      <= 4'h0;
                    capOnPositive <= 1'b0;
                    dacCode       <= `ADCSC_TRIAL_MSB;
                    bipolarFlip   <= ~heldByte[`ADCSC_POLARITY_BIT];
                    strobeOut <= (heldByte[1:0] == `ADCSC_MODE_EXT_CLOCK);
                    doutOut       <= 1'b0;
                end else if (convActive) begin
                    strobeOut <= 1'b0;
                    // msb first; bipolar inverts the msb for two's complement
                    if (convStep == 4'h0) begin
                        doutOut <= compSync ^ bipolarFlip;
                    end else begin
                        doutOut <= compSync;
                    end
                    dacCode  <= decidedCode | (trialMask >> 1);
                    convStep <= convStep + 4'h1;
                    if (convStep == `ADCSC_RESULT_BITS - 4'h1) begin
                        convActive    <= 1'b0;
                        capOnPositive <= 1'b1;
                        dacCode       <= decidedCode;
                        fifoPush      <= 1'b1;
                        fifoData      <= {ctrlByte,
                                          decidedCode[11] ^ bipolarFlip,
                                          decidedCode[10:0]};
                    end
                end else begin
                    strobeOut <= 1'b0;
                    doutOut   <= 1'b0;
                end
            end
        end
    end

    adcsc_fifo #(
        .WIDTH (20),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (fifoData),
        .outValid (resultValid),
        .outReady (resultReady),
        .outData  (resultData)
    );
endmodule // adcsc_serial_ctrl

/* File: sim/adcsc_serial_ctrl_properties.sv */
// concurrent checks on the serial control block ports
`timescale 1ns/1ps
module adcsc_checker (
    input wire        mclk,
    input wire        reset_n,
    input wire        csN,
    input wire        sclk,
    input wire        doutOut,
    input wire        doutOe,
    input wire        strobeOut,
    input wire        strobeOe,
    input wire        trackMode,
    input wire        capOnPositive,
    input wire [11:0] dacCode,
    input wire        convActive,
    input wire        resultValid,
    input wire        resultReady
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    oe_float_a: assert property (csN [*4] |-> !doutOe && !strobeOe)
        else $error("outputs driven while deselected");
    oe_on_a: assert property (!csN [*4] |-> doutOe && strobeOe)
        else $error("outputs floating while selected");
    strobe_width_a: assert property ($rose(strobeOut) |->
        strobeOut [*8] ##1 strobeOut [*4] ##[1:2] !strobeOut)
        else $error("strobe pulse not one serial period");
    hold_at_strobe_a: assert property ($rose(strobeOut) |->
        !trackMode && !capOnPositive && dacCode == 12'h800)
        else $error("strobe without hold and msb trial");
    acq_window_a: assert property ($rose(trackMode) |->
        trackMode [*8] ##[28:32] $fell(trackMode))
        else $error("acquisition not three serial clocks");
    edge_align_a: assert property (($changed(doutOut) || $changed(strobeOut)) |->
        !sclk && !$past(sclk, 3))
        else $error("output moved away from a serial fall");
    cap_return_a: assert property ($rose(capOnPositive) |-> ##[0:2] !convActive)
        else $error("hold cap back while converting");
    result_push_a: assert property ($rose(capOnPositive) && !csN |-> ##[1:3] resultValid)
        else $error("finished conversion not queued");
    cover property ($rose(strobeOut));
    cover property (resultValid && resultReady);
    cover property ($fell(doutOe));
endmodule // adcsc_checker

bind adcsc_serial_ctrl adcsc_checker chk (.mclk, .reset_n, .csN, .sclk, .doutOut, .doutOe,
    .strobeOut, .strobeOe, .trackMode, .capOnPositive, .dacCode, .convActive, .resultValid,
    .resultReady);

/* File: sim/adcsc_host_model.sv */
// serial host model: mode 0 master driving select, clock and data
`timescale 1ns/1ps
module adcsc_host_model (
    output reg  csN,
    output reg  sclk,
    output reg  din,
    input  wire dout,
    input  wire doutOe
);
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // one call per chip-select frame: n bits of tx out, n dout samples into rx
    // ideal comparator: the short bench acquisition window loses no charge
    task frame(input [63:0] tx, input integer n, output [63:0] rx);
        integer k;
        reg     last;
        begin
            rx = 64'h0;
            last = 1'b0;
            csN <= 1'b0;
            #250;
            for (k = n - 1; k >= 0; k--) begin
                din <= tx[k];
                #62.5;
                sclk <= 1'b1;
                rx = {rx[62:0], doutOe ? dout : ~last};
                last = rx[0];
                #62.5;
                sclk <= 1'b0;
            end
            #250;
            csN <= 1'b1;
            din <= ~din;
            #500;
        end
    endtask
endmodule // adcsc_host_model

/* File: sim/tb_adcsc_serial_ctrl.sv */
// self-checking bench for the serial control block
`timescale 1ns/1ps
module tb_adcsc_serial_ctrl;
    reg          mclk = 1'b0;
    reg          reset_n = 1'b0;
    reg          compHigh = 1'b0;
    reg          resultReady = 1'b0;
    reg          sPrev = 1'b0;
    reg   [11:0] vin = 12'h000;
    reg   [63:0] rx;
    reg   [31:0] r;
    wire         csN, sclk, din, doutOut, doutOe, strobeOut, muxNegIsCom, polarityUnipolar;
    wire         resultValid;
    wire  [11:0] dacCode;
    wire  [2:0]  muxPos, muxNeg;
    wire  [1:0]  powerClockMode;
    wire  [19:0] resultData;
    integer      err_count = 0, n_tests = 0, nStrobe = 0, i, s0;
    logic [19:0] exq[$];

    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        compHigh <= (vin >= dacCode);
        sPrev <= strobeOut;
        if (strobeOut && !sPrev) nStrobe <= nStrobe + 1;
    end

    adcsc_serial_ctrl DUT (.mclk, .reset_n, .csN, .sclk, .din, .compHigh, .doutOut, .doutOe,
        .strobeOut, .strobeOe(), .trackMode(), .capOnPositive(), .dacCode, .muxPos, .muxNeg,
        .muxNegIsCom, .polarityUnipolar, .powerClockMode, .convActive(), .resultValid,
        .resultReady, .resultData);
    adcsc_host_model host (.csN, .sclk, .din, .dout(doutOut), .doutOe);

    function [19:0] expWord(input [7:0] c, input [11:0] v);
        expWord = {c, c[3] ? v : v ^ 12'h800};
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task conv(input [7:0] c, input integer lead);
        integer     s;
        reg  [19:0] w;
        begin
            vin = $urandom;
            s = nStrobe;
            w = expWord(c, vin);
            host.frame({40'h0, c, 16'h0}, lead + 24, rx);
            exq.push_back(w);
            chk(rx[23:0], {9'h0, w[11:0], 3'h0});
            chk(nStrobe - s, c[1:0] == 2'h3);
            chk(muxPos, {c[5:4], c[6]});
            chk(muxNegIsCom, c[2]);
            if (!c[2]) chk(muxNeg, {c[5:4], ~c[6]});
            chk(polarityUnipolar, c[3]);
            chk(powerClockMode, c[1:0]);
        end
    endtask

    task drain;
        integer k;
        begin
            @(posedge mclk) resultReady <= 1'b1;
            for (k = 0; k < 12; k++) begin
                @(negedge mclk);
                if (resultValid === 1'b1) chk(resultData, exq.size() ? exq.pop_front() : 20'hx);
                @(posedge mclk);
            end
            resultReady <= 1'b0;
            chk(exq.size(), 0);
            chk(resultValid, 0);
            exq.delete();
        end
    endtask

    initial begin
        void'($urandom(32'h0000_ff54));
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (10) @(posedge mclk);
        for (i = 0; i < 32; i++) begin
            r = $urandom;
            conv({1'b1, i[2:0], r[0], i[3], i[4] ? 2'h3 : r[2:1]}, r[5:3]);
            drain();
        end
        host.frame(64'hB, 4, rx); // partial byte then deselect
        conv(8'h9F, 2);
        drain();
        s0 = nStrobe;
        vin = $urandom;
        host.frame(64'hFFFF_FFFF_FFFF, 45, rx); // din tied high, third conversion aborted
        chk(rx[35:24], vin);
        chk(rx[20:9], vin);
        chk(nStrobe - s0, 3);
        chk(muxPos, 3'h7);
        exq.push_back(expWord(8'hFF, vin));
        exq.push_back(expWord(8'hFF, vin));
        drain();
        for (i = 0; i < 8; i++) conv(8'h8F, 0);
        s0 = nStrobe;
        host.frame(64'h00FF_0000, 24, rx); // start refused while full
        chk(resultValid, 1);
        chk(nStrobe - s0, 0);
        chk(rx[23:0], 24'h00_0000);
        drain();
        wrap_up();
    end

    initial begin
        #900000;
        err_count++;
        wrap_up();
    end
endmodule // tb_adcsc_serial_ctrl
